// >>> logic/cpu_interrupt_interface.v
// Purpose: per-core interrupt input boundary and CPU interface message streams
// Assumes: four cores, one clock, request pins asynchronous to clk
// Notes: registers over AXI4-Lite; legacy lines bypass when the bypass pin is high
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`include "cpu_interrupt_interface_defines.vh"

module cpu_interrupt_interface (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Interrupt request pins, bypass pin and register base address
  input wire [3:0] fast_intr_req_n,
  input wire [3:0] intr_req_n,
  input wire [3:0] virt_fast_intr_req_n,
  input wire [3:0] virt_intr_req_n,
  input wire [3:0] sys_err_req_n,
  input wire [3:0] virt_sys_err_req_n,
  input wire [3:0] ram_err_req_n,
  input wire cpu_if_bypass,
  input wire [21:0] intc_reg_base_addr,
  // Maintenance interrupt
  output wire [3:0] virt_maint_intr_n,
  // Requests towards the cores
  output reg [3:0] coreFastReq,
  output reg [3:0] coreIntrReq,
  output reg [3:0] coreVirtFastReq,
  output reg [3:0] coreVirtIntrReq,
  output reg [3:0] coreAbortPulse,
  output reg [3:0] coreSerrorPulse,
  // Inbound distributor stream
  input wire dist_in_valid,
  output wire dist_in_ready,
  input wire [15:0] dist_in_payload,
  input wire dist_in_last,
  input wire [1:0] dist_in_route,
  // Outbound stream
  output wire cpuif_out_valid,
  input wire cpuif_out_ready,
  output reg [15:0] cpuif_out_payload,
  output reg cpuif_out_last,
  output reg [1:0] cpuif_out_stream_id,
  // AXI4-Lite slave
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  function mapped;
    input [4:0] addr;
    begin
      mapped = (addr[1:0] == 2'h0);
    end
  endfunction

  function [31:0] strbMask;
    input [3:0] strb;
    begin
      strbMask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  // Three-stage synchroniser; a change counts once stages two and three agree
  wire [28:0] rawIn;
  reg [28:0] syncA_ff;
  reg [28:0] syncB_ff;
  reg [28:0] syncC_ff;
  reg [28:0] filt_ff;
  reg [11:0] prevErr_ff;
  assign rawIn = {cpu_if_bypass, ram_err_req_n, virt_sys_err_req_n, sys_err_req_n,
                  virt_intr_req_n, virt_fast_intr_req_n, intr_req_n, fast_intr_req_n};

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA_ff <= `SYNC_RST;
      syncB_ff <= `SYNC_RST;
      syncC_ff <= `SYNC_RST;
      filt_ff <= `SYNC_RST;
      prevErr_ff <= 12'hfff;
    end else begin
      syncA_ff <= rawIn;
      syncB_ff <= syncA_ff;
      syncC_ff <= syncB_ff;
      filt_ff <= (syncB_ff & syncC_ff) | (filt_ff & (syncB_ff | syncC_ff));
      prevErr_ff <= filt_ff[27:16];
    end
  end

  wire bypass = filt_ff[28];
  wire [3:0] fastN = filt_ff[3:0];
  wire [3:0] intrN = filt_ff[7:4];
  wire [3:0] vFastN = filt_ff[11:8];
  wire [3:0] vIntrN = filt_ff[15:12];
  // Falling edges of system, virtual system and RAM error lines
  wire [11:0] errFell = prevErr_ff & ~filt_ff[27:16];

  // Base address sampled once at reset release
  reg [21:0] cfgBase_ff;
  reg capDone_ff;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfgBase_ff <= 22'h000000;
      capDone_ff <= 1'b0;
    end else if (!capDone_ff) begin
      cfgBase_ff <= intc_reg_base_addr;
      capDone_ff <= 1'b1;
    end
  end

  // Software state
  reg [31:0] ctrl_ff;
  reg [11:0] errSticky_ff;
  reg [9:0] faultStatus_ff;
  reg [31:0] syndrome_ff;
  reg [17:0] rxMsg_ff;
  reg rxValid_ff;
  reg txBusy_ff;
  wire [3:0] exec64 = ctrl_ff[`CTRL_EXEC64_LSB +: 4];

  // Core request routing
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      coreFastReq <= 4'h0;
      coreIntrReq <= 4'h0;
      coreVirtFastReq <= 4'h0;
      coreVirtIntrReq <= 4'h0;
      coreAbortPulse <= 4'h0;
      coreSerrorPulse <= 4'h0;
    end else begin
      coreFastReq <= ~fastN;
      coreIntrReq <= ~intrN;
      if (bypass) begin
        coreVirtFastReq <= ~vFastN;
        coreVirtIntrReq <= ~vIntrN;
      end else begin
        coreVirtFastReq <= ctrl_ff[`CTRL_VFIQ_LSB +: 4];
        coreVirtIntrReq <= ctrl_ff[`CTRL_VIRQ_LSB +: 4];
      end
      coreAbortPulse <= (errFell[3:0] | errFell[7:4] | errFell[11:8]) & ~exec64;
      coreSerrorPulse <= (errFell[3:0] | errFell[7:4] | errFell[11:8]) & exec64;
    end
  end

  assign virt_maint_intr_n = ~ctrl_ff[`CTRL_MAINT_LSB +: 4];

  // Latest error event of any kind, lowest core first
  reg [9:0] nxtFault;
  reg [31:0] nxtSyn;
  reg errHit;
  integer i;
  always @* begin
    nxtFault = faultStatus_ff;
    nxtSyn = syndrome_ff;
    errHit = 1'b0;
    for (i = 3; i >= 0; i = i - 1) begin
      if (errFell[`ERR_RAM_LSB + i]) begin
        nxtFault = {i[1:0], exec64[i], 2'h0, `FS_ASYNC_PARITY};
        nxtSyn = {`EC_SERROR, 1'b0, `ISS_RAM_ERR};
        errHit = 1'b1;
      end else if (errFell[`ERR_SYS_LSB + i] | errFell[`ERR_VSYS_LSB + i]) begin
        nxtFault = {i[1:0], exec64[i], 2'h0, `FS_ASYNC_EXT_ABORT};
        nxtSyn = {`EC_SERROR, 1'b0, `ISS_SYS_ERR};
        errHit = 1'b1;
      end
    end
  end

  // AXI4-Lite write path
  reg awHeld_ff;
  reg wHeld_ff;
  reg [4:0] awAddr_ff;
  reg [31:0] wData_ff;
  reg [3:0] wStrb_ff;
  assign s_axi_awready = !awHeld_ff && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_ff && !s_axi_bvalid;
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire doWrite = awHeld_ff && wHeld_ff;
  wire [31:0] wMask = strbMask(wStrb_ff);
  wire [31:0] wMerged = (ctrl_ff & ~wMask) | (wData_ff & wMask);
  wire wrCtrl = doWrite && awAddr_ff == `OFF_CTRL;
  wire wrErr = doWrite && awAddr_ff == `OFF_ERR_STATUS;
  wire wrTx = doWrite && awAddr_ff == `OFF_TX_MSG && !txBusy_ff;

  // AXI4-Lite read path
  assign s_axi_arready = !s_axi_rvalid;
  wire arTake = s_axi_arvalid && s_axi_arready;
  reg [31:0] rdVal;
  always @* begin
    rdVal = 32'h00000000;
    case (s_axi_araddr)
      `OFF_CTRL: rdVal = ctrl_ff;
      `OFF_STATUS: rdVal = {3'h0, bypass, 12'h000, ~filt_ff[15:0]};
      `OFF_ERR_STATUS: rdVal = {20'h00000, errSticky_ff};
      `OFF_FAULT_STATUS: rdVal = {22'h000000, faultStatus_ff};
      `OFF_SYNDROME: rdVal = syndrome_ff;
      `OFF_CONFIG_BASE: rdVal = {cfgBase_ff, 10'h000};
      `OFF_RX_MSG: rdVal = {rxValid_ff, 13'h0000, rxMsg_ff};
      `OFF_TX_MSG: rdVal = {txBusy_ff, 31'h00000000};
      default: rdVal = 32'h00000000;
    endcase
  end
  wire rxRead = arTake && s_axi_araddr == `OFF_RX_MSG;

  // Streams are idle while the interface is bypassed
  assign dist_in_ready = !bypass && !rxValid_ff;
  wire inTake = dist_in_valid && dist_in_ready;
  assign cpuif_out_valid = txBusy_ff && !bypass;
  wire outTake = cpuif_out_valid && cpuif_out_ready;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= 5'h00;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      ctrl_ff <= `CTRL_RESET;
      errSticky_ff <= 12'h000;
      faultStatus_ff <= 10'h000;
      syndrome_ff <= 32'h00000000;
      rxMsg_ff <= 18'h00000;
      rxValid_ff <= 1'b0;
      txBusy_ff <= 1'b0;
      cpuif_out_payload <= 16'h0000;
      cpuif_out_last <= 1'b0;
      cpuif_out_stream_id <= 2'h0;
    end else begin
      if (awTake) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (wTake) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awAddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (arTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdVal;
        s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (wrCtrl) begin
        ctrl_ff <= {16'h0000, wMerged[15:0]};
      end
      // New error events win over a simultaneous clear
      errSticky_ff <= (wrErr ? errSticky_ff & ~(wData_ff[11:0] & wMask[11:0]) : errSticky_ff)
                      | errFell;
      if (errHit) begin
        faultStatus_ff <= nxtFault;
        syndrome_ff <= nxtSyn;
      end
      // Inbound beat held until software reads it; last is copied into the CTRL maintenance bit of the routed core
      if (inTake) begin
        rxMsg_ff <= {dist_in_route, dist_in_payload};
        rxValid_ff <= 1'b1;
        ctrl_ff[`CTRL_MAINT_LSB + dist_in_route] <= dist_in_last;
      end else if (rxRead) begin
        rxValid_ff <= 1'b0;
      end
      if (wrTx) begin
        cpuif_out_payload <= wData_ff[15:0];
        cpuif_out_last <= wData_ff[`MSG_LAST_BIT];
        cpuif_out_stream_id <= wData_ff[`MSG_SIDE_LSB +: 2];
        txBusy_ff <= 1'b1;
      end else if (outTake) begin
        txBusy_ff <= 1'b0;
      end
    end
  end

endmodule // cpu_interrupt_interface

// >>> logic/cpu_interrupt_interface_defines.vh
`ifndef CPU_INTERRUPT_INTERFACE_DEFINES_VH
`define CPU_INTERRUPT_INTERFACE_DEFINES_VH
// Core count: highest core index 3, four cores
`define NUM_CORES 4
// Register byte offsets
`define OFF_CTRL 5'h00
`define OFF_STATUS 5'h04
`define OFF_ERR_STATUS 5'h08
`define OFF_FAULT_STATUS 5'h0c
`define OFF_SYNDROME 5'h10
`define OFF_CONFIG_BASE 5'h14
`define OFF_RX_MSG 5'h18
`define OFF_TX_MSG 5'h1c
// CTRL fields
`define CTRL_EXEC64_LSB 0
`define CTRL_VFIQ_LSB 4
`define CTRL_VIRQ_LSB 8
`define CTRL_MAINT_LSB 12
`define CTRL_RESET 32'h00000000
// ERR_STATUS fields, four bits per kind
`define ERR_SYS_LSB 0
`define ERR_VSYS_LSB 4
`define ERR_RAM_LSB 8
// Message fields in RX and TX registers
`define MSG_LAST_BIT 16
`define MSG_SIDE_LSB 17
`define RX_VALID_BIT 31
`define TX_BUSY_BIT 31
// Fault status codes for 32-bit state
`define FS_ASYNC_EXT_ABORT 5'h16
`define FS_ASYNC_PARITY 5'h18
// Syndrome values for 64-bit state
`define ISS_SYS_ERR 25'h0000000
`define ISS_RAM_ERR 25'h0000001
`define EC_SERROR 6'h2f
// Synchroniser reset: request lines inactive high, bypass low
`define SYNC_RST 29'h0fffffff
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> tb/cpu_interrupt_interface_properties.sv
// Purpose: port-level properties of the interrupt interface
// Assumes: request pins are held steady for several cycles at a time
// Notes: bound into every instance of the design after the module
module cpu_interrupt_interface_properties (
  // Clock and reset
  input logic clk,
  input logic sys_rst,
  // Request pins and bypass pin
  input logic [3:0] fast_intr_req_n,
  input logic [3:0] intr_req_n,
  input logic [3:0] virt_fast_intr_req_n,
  input logic [3:0] sys_err_req_n,
  input logic cpu_if_bypass,
  // Core side
  input logic [3:0] coreFastReq,
  input logic [3:0] coreIntrReq,
  input logic [3:0] coreVirtFastReq,
  input logic [3:0] coreAbortPulse,
  input logic [3:0] coreSerrorPulse,
  // Streams
  input logic dist_in_valid,
  input logic dist_in_ready,
  input logic cpuif_out_valid,
  input logic cpuif_out_ready,
  input logic [15:0] cpuif_out_payload
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_fast_level;
    $stable(fast_intr_req_n)[*7] |-> coreFastReq == ~fast_intr_req_n;
  endproperty
  a_fast_level: assert property (p_fast_level) else $error("fast level wrong");
  property p_intr_level;
    $stable(intr_req_n)[*7] |-> coreIntrReq == ~intr_req_n;
  endproperty
  a_intr_level: assert property (p_intr_level) else $error("normal level wrong");
  property p_virt_bypass;
    (cpu_if_bypass && $stable(virt_fast_intr_req_n))[*7] |->
      coreVirtFastReq == ~virt_fast_intr_req_n;
  endproperty
  a_virt_bypass: assert property (p_virt_bypass) else $error("virtual route wrong");
  property p_bypass_quiet;
    cpu_if_bypass[*6] |-> !dist_in_ready && !cpuif_out_valid;
  endproperty
  a_bypass_quiet: assert property (p_bypass_quiet) else $error("streams live in bypass");
  property p_err_event;
    $fell(sys_err_req_n[0]) |-> ##[2:8] (coreAbortPulse[0] || coreSerrorPulse[0]);
  endproperty
  a_err_event: assert property (p_err_event) else $error("no error event");
  property p_pulse_once;
    (coreAbortPulse | coreSerrorPulse) != 4'h0 |=> (coreAbortPulse | coreSerrorPulse) == 4'h0;
  endproperty
  a_pulse_once: assert property (p_pulse_once) else $error("error pulse too long");
  property p_in_hold;
    dist_in_valid && dist_in_ready |=> !dist_in_ready;
  endproperty
  a_in_hold: assert property (p_in_hold) else $error("inbound ready after beat");
  property p_out_hold;
    cpuif_out_valid && !cpuif_out_ready |=> cpuif_out_valid && $stable(cpuif_out_payload);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("outbound beat dropped");
endmodule // cpu_interrupt_interface_properties

bind cpu_interrupt_interface cpu_interrupt_interface_properties chk_u (.*);

// >>> tb/dist_model.sv
// Purpose: behavioural distributor on both message streams
// Assumes: one beat per message
// Notes: stalls outbound ready for stallLen + 1 cycles of valid
module dist_model (
  // Clock
  input logic clk,
  // Inbound stream, driven here
  output logic dist_in_valid,
  output logic [15:0] dist_in_payload,
  output logic dist_in_last,
  output logic [1:0] dist_in_route,
  input logic dist_in_ready,
  // Outbound stream, taken here
  input logic cpuif_out_valid,
  input logic [15:0] cpuif_out_payload,
  input logic cpuif_out_last,
  input logic [1:0] cpuif_out_stream_id,
  output logic cpuif_out_ready,
  // Stall length and last message taken
  input logic [3:0] stallLen,
  output logic [18:0] gotMsg
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] waitCnt;
  initial begin
    dist_in_valid = 1'b0;
    dist_in_payload = 16'h5a5a;
    dist_in_last = 1'b0;
    dist_in_route = 2'h0;
    cpuif_out_ready = 1'b0;
    waitCnt = 4'h0;
    gotMsg = 19'h0;
  end
  // Hold the beat until taken, then scramble the released lines
  task sendBeat(input logic [15:0] d, input logic [1:0] rt, input logic lst);
    dist_in_valid <= 1'b1;
    dist_in_payload <= d;
    dist_in_last <= lst;
    dist_in_route <= rt;
    do @(posedge clk); while (!dist_in_ready);
    dist_in_valid <= 1'b0;
    dist_in_payload <= ~d;
    dist_in_last <= ~lst;
    dist_in_route <= ~rt;
  endtask
  always @(posedge clk) begin
    if (cpuif_out_valid && cpuif_out_ready) begin
      gotMsg <= {cpuif_out_stream_id, cpuif_out_last, cpuif_out_payload};
      cpuif_out_ready <= 1'b0;
      waitCnt <= 4'h0;
    end else if (cpuif_out_valid) begin
      waitCnt <= waitCnt + 4'h1;
      if (waitCnt >= stallLen) cpuif_out_ready <= 1'b1;
    end
  end
endmodule // dist_model

// >>> tb/cpu_interrupt_interface_tb.sv
// Purpose: register-driven test of the interrupt interface
// Assumes: four cores, register map from the shared header
// Notes: pins driven on the rising edge by non-blocking assignment
`include "cpu_interrupt_interface_defines.vh"
module cpu_interrupt_interface_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, sys_rst, cpu_if_bypass, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic [3:0] fast_intr_req_n, intr_req_n, virt_fast_intr_req_n, virt_intr_req_n;
  logic [3:0] sys_err_req_n, virt_sys_err_req_n, ram_err_req_n, s_axi_wstrb, stallLen;
  logic [3:0] seenAbort, seenSerr;
  logic [21:0] intc_reg_base_addr;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd;
  logic [1:0] rs;
  wire [3:0] virt_maint_intr_n, coreFastReq, coreIntrReq, coreVirtFastReq, coreVirtIntrReq;
  wire [3:0] coreAbortPulse, coreSerrorPulse;
  wire dist_in_valid, dist_in_ready, dist_in_last, cpuif_out_valid, cpuif_out_ready;
  wire cpuif_out_last, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [15:0] dist_in_payload, cpuif_out_payload;
  wire [1:0] dist_in_route, cpuif_out_stream_id, s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [18:0] gotMsg;
  int badCount, numChecks;
  cpu_interrupt_interface dut_u (.*);
  dist_model dist_u (.*);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    seenAbort <= sys_rst ? 4'h0 : seenAbort | coreAbortPulse;
    seenSerr <= sys_rst ? 4'h0 : seenSerr | coreSerrorPulse;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task axiWrite(input logic [4:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task axiRead(input logic [4:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    summarize;
  end
  initial begin
    {sys_rst, cpu_if_bypass, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h10;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 12'h0;
    {fast_intr_req_n, intr_req_n, virt_fast_intr_req_n, virt_intr_req_n} = 16'hffff;
    {sys_err_req_n, virt_sys_err_req_n, ram_err_req_n} = 12'hfff;
    {s_axi_wstrb, stallLen, s_axi_wdata} = {4'hf, 4'h3, 32'h0};
    intc_reg_base_addr = 22'h2a5c3;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    intc_reg_base_addr <= 22'h0;
    axiRead(`OFF_CONFIG_BASE);
    chk(rd, 32'h0a970c00);
    fast_intr_req_n <= 4'ha;
    intr_req_n <= 4'h3;
    repeat (8) @(posedge clk);
    chk({coreFastReq, coreIntrReq}, 8'h5c);
    {fast_intr_req_n, intr_req_n} <= 8'hff;
    repeat (8) @(posedge clk);
    chk({coreFastReq, coreIntrReq}, 8'h00);
    for (int k = 0; k < 3; k++) begin
      {ram_err_req_n, virt_sys_err_req_n, sys_err_req_n} <= ~(12'h2 << (4 * k));
      repeat (10) @(posedge clk);
      axiRead(`OFF_FAULT_STATUS);
      chk(rd, (k == 2) ? 32'h118 : 32'h116);
      axiRead(`OFF_ERR_STATUS);
      chk(rd, 32'h2 << (4 * k));
      axiWrite(`OFF_ERR_STATUS, 32'h2 << (4 * k));
      chk(rs, `RESP_OKAY);
      axiRead(`OFF_ERR_STATUS);
      chk(rd, 32'h0);
      {ram_err_req_n, virt_sys_err_req_n, sys_err_req_n} <= 12'hfff;
      // Let the release reach the first synchroniser stage before the next line falls
      @(posedge clk);
    end
    axiWrite(`OFF_CTRL, 32'h1);
    sys_err_req_n <= 4'he;
    repeat (10) @(posedge clk);
    axiRead(`OFF_SYNDROME);
    chk(rd, 32'hbc000000);
    chk({seenAbort, seenSerr}, 8'h21);
    sys_err_req_n <= 4'hf;
    axiWrite(`OFF_CTRL, 32'h330);
    repeat (3) @(posedge clk);
    chk({coreVirtFastReq, coreVirtIntrReq}, 8'h33);
    cpu_if_bypass <= 1'b1;
    virt_fast_intr_req_n <= 4'h6;
    virt_intr_req_n <= 4'h5;
    repeat (10) @(posedge clk);
    chk({coreVirtFastReq, coreVirtIntrReq, 3'h0, dist_in_ready}, 12'h9a0);
    cpu_if_bypass <= 1'b0;
    virt_fast_intr_req_n <= 4'hf;
    virt_intr_req_n <= 4'hf;
    repeat (10) @(posedge clk);
    dist_u.sendBeat(16'h1234, 2'h2, 1'b1);
    repeat (3) @(posedge clk);
    chk({virt_maint_intr_n, 3'h0, dist_in_ready}, 8'hb0);
    axiRead(`OFF_RX_MSG);
    chk(rd, 32'h80021234);
    axiWrite(`OFF_TX_MSG, 32'h0007beef);
    chk(rs, `RESP_OKAY);
    repeat (12) @(posedge clk);
    chk(gotMsg, 19'h7beef);
    axiRead(`OFF_TX_MSG);
    chk(rd[31], 1'b0);
    axiRead(5'h02);
    chk(rs, `RESP_SLVERR);
    summarize;
  end
endmodule // cpu_interrupt_interface_tb
